// [ods_params.svh]
// Register indices, field positions, reset values and timing for the servo
`ifndef ODS_PARAMS_SVH
`define ODS_PARAMS_SVH

`define ODS_IDX_W            8
`define ODS_IDX_CTRL         8'h43
`define ODS_IDX_MODE         8'h45
`define ODS_IDX_PRESET_HPL   8'h47
`define ODS_IDX_PRESET_HPR   8'h48
`define ODS_IDX_PRESET_LNL   8'h49
`define ODS_IDX_PRESET_LNR   8'h4a
`define ODS_IDX_RDBK_HPL     8'h51
`define ODS_IDX_RDBK_HPR     8'h52
`define ODS_IDX_RDBK_LNL     8'h53
`define ODS_IDX_RDBK_LNR     8'h54

`define ODS_CTRL_MASTER_BIT  4
`define ODS_CTRL_SEL_MSB     3
`define ODS_CTRL_SEL_LSB     0
`define ODS_MODE_MSB         1
`define ODS_MODE_LSB         0
`define ODS_MODE_MEASURE_BIT 1
`define ODS_MODE_PERIOD_BIT  0

`define ODS_CTRL_RESET       8'h10
`define ODS_MODE_RESET       2'h0
`define ODS_PRESET_RESET     8'h00
`define ODS_CORR_RESET       8'h00

`define ODS_CLK_HZ           64'd40000000
`define ODS_UPDATE_MINUTES   64'd10
`define ODS_SEC_PER_MINUTE   64'd60
`define ODS_UPDATE_CYCLES    (`ODS_UPDATE_MINUTES * `ODS_SEC_PER_MINUTE * `ODS_CLK_HZ)
`define ODS_TIMER_W          36

`endif

// [ods_pkg.sv]
// Types shared by the offset servo control
package ods_pkg;

   typedef enum logic [1:0] {
      ODS_MODE_PRESET_ONCE   = 2'h0,
      ODS_MODE_PRESET_PERIOD = 2'h1,
      ODS_MODE_MEASURE_ONCE  = 2'h2,
      ODS_MODE_MEASURE_PERIOD = 2'h3
   } ods_mode_t;

   typedef enum logic [1:0] {
      ODS_CH_IDLE,
      ODS_CH_MEASURE,
      ODS_CH_RUN
   } ods_chan_state_t;

   // Correction handed to one output stage
   typedef struct packed {
      logic       apply;
      logic [7:0] value;
   } ods_corr_t;

   // Measurement result from one output's offset sensor
   typedef struct packed {
      logic       valid;
      logic [7:0] value;
   } ods_meas_t;

endpackage : ods_pkg

// [ods_chan.sv]
// One output's correction holder and measurement sequencer
`timescale 1ns/100ps
`include "ods_params.svh"

module ods_chan (
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   input  wire logic                   master_on,
   input  wire logic                   out_en,
   input  wire logic [1:0]             op_mode,
   input  wire logic                   restart,
   input  wire logic                   tick,
   input  wire logic [7:0]             preset,
   input  wire ods_pkg::ods_meas_t     meas,
   output logic                        meas_req,
   output ods_pkg::ods_corr_t          corr
);

   ods_pkg::ods_chan_state_t state;
   logic [7:0]               value;
   logic                     have;

   wire measure_mode = op_mode[`ODS_MODE_MEASURE_BIT];
   wire period_mode  = op_mode[`ODS_MODE_PERIOD_BIT];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ods_pkg::ODS_CH_IDLE;
         value <= `ODS_CORR_RESET;
         have  <= 1'b0;
      end else if (!master_on) begin
         state <= ods_pkg::ODS_CH_IDLE;
         value <= `ODS_CORR_RESET;
         have  <= 1'b0;
      end else if (restart) begin
         // New mode forgets the old value and starts over
         state <= ods_pkg::ODS_CH_IDLE;
         have  <= 1'b0;
      end else begin
         unique case (state)
            ods_pkg::ODS_CH_IDLE: begin
               if (out_en) begin
                  if (have) begin
                     state <= ods_pkg::ODS_CH_RUN;
                  end else if (measure_mode) begin
                     state <= ods_pkg::ODS_CH_MEASURE;
                  end else begin
                     value <= preset;
                     have  <= 1'b1;
                     state <= ods_pkg::ODS_CH_RUN;
                  end
               end
            end
            ods_pkg::ODS_CH_MEASURE: begin
               if (!out_en) begin
                  state <= ods_pkg::ODS_CH_IDLE;
               end else if (meas.valid) begin
                  value <= meas.value;
                  have  <= 1'b1;
                  state <= ods_pkg::ODS_CH_RUN;
               end
            end
            ods_pkg::ODS_CH_RUN: begin
               if (!out_en) begin
                  state <= ods_pkg::ODS_CH_IDLE;
               end else if (tick && period_mode) begin
                  state <= ods_pkg::ODS_CH_MEASURE;
               end
            end
            // Spare state code falls back to idle
            default: begin
               state <= ods_pkg::ODS_CH_IDLE;
            end
         endcase
      end
   end

   // Old value stays applied while a refresh measurement runs
   assign meas_req   = master_on && out_en &&
                       (state == ods_pkg::ODS_CH_MEASURE);
   assign corr.apply = master_on && out_en && have;
   assign corr.value = value;

endmodule : ods_chan

// [ods_servo_ctrl.sv]
// Offset servo control: Wishbone registers, update timer, four channels
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ods_params.svh"

// Notes on behaviour
// - With the master enable at zero the servo is held in reset and no output is corrected.
// - A four-bit select enables headphone left, headphone right, line left and line right from bit 3 down.
// - Mode 10 measures each enabled output once and then keeps that correction.
// - Mode 11 measures at start and then again every update interval, ten minutes by default.
// - Mode 00 loads each enabled output's correction from its preset and does nothing more.
// - Mode 01 starts from the presets and then measures again every update interval.
// - Clearing an output's select with the master on keeps its value and re-applies it later.
// - Each preset is an eight-bit two's complement value of a quarter millivolt per count.
// - Four read-only readback registers show each output's live correction; writes do nothing.
module ods_servo_ctrl #(
   parameter logic [`ODS_TIMER_W-1:0] UPDATE_CYCLES =
      `ODS_TIMER_W'(`ODS_UPDATE_CYCLES)
) (
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic [9:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   input  wire logic                  wb_we_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output logic                       wb_ack_o,
   input  wire ods_pkg::ods_meas_t [3:0] meas_in,
   output logic      [3:0]            meas_req,
   output ods_pkg::ods_corr_t [3:0]   corr_out
);

   function automatic logic idx_hit(input logic [7:0] idx,
                                    input logic [7:0] target);
      idx_hit = (idx == target);
   endfunction : idx_hit

   logic [7:0]             ctrl_reg;
   logic [1:0]             mode_reg;
   logic [3:0][7:0]        preset;
   logic [31:0]            rd_data;
   logic                   ack;
   logic                   restart;
   logic                   tick;
   logic [`ODS_TIMER_W-1:0] timer;

   wire [7:0] idx     = wb_adr_i[9:2];
   wire       req     = wb_cyc_i && wb_stb_i && !ack;
   wire       wr_lane = req && wb_we_i && wb_sel_i[0];
   wire [7:0] wbyte   = wb_dat_i[7:0];

   wire hit_ctrl = idx_hit(idx, `ODS_IDX_CTRL);
   wire hit_mode = idx_hit(idx, `ODS_IDX_MODE);
   wire [3:0] hit_preset = {idx_hit(idx, `ODS_IDX_PRESET_HPL),
                            idx_hit(idx, `ODS_IDX_PRESET_HPR),
                            idx_hit(idx, `ODS_IDX_PRESET_LNL),
                            idx_hit(idx, `ODS_IDX_PRESET_LNR)};
   wire [3:0] hit_rdbk   = {idx_hit(idx, `ODS_IDX_RDBK_HPL),
                            idx_hit(idx, `ODS_IDX_RDBK_HPR),
                            idx_hit(idx, `ODS_IDX_RDBK_LNL),
                            idx_hit(idx, `ODS_IDX_RDBK_LNR)};

   wire       master_on  = ctrl_reg[`ODS_CTRL_MASTER_BIT];
   wire [3:0] out_sel    = ctrl_reg[`ODS_CTRL_SEL_MSB:`ODS_CTRL_SEL_LSB];
   wire       wr_ctrl    = wr_lane && hit_ctrl;
   wire       wr_mode    = wr_lane && hit_mode;
   wire [1:0] next_mode  = wbyte[`ODS_MODE_MSB:`ODS_MODE_LSB];
   wire       next_master = wbyte[`ODS_CTRL_MASTER_BIT];
   wire       next_restart = (wr_mode && next_mode != mode_reg) ||
                             (wr_ctrl && next_master && !master_on);
   wire       periodic   = mode_reg[`ODS_MODE_PERIOD_BIT];
   wire       timer_end  = (timer == UPDATE_CYCLES - `ODS_TIMER_W'(1));

   // Unmapped indices answer with zero; readbacks ignore writes
   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_data[7:0] = {3'h0, ctrl_reg[4:0]};
      end
      if (hit_mode) begin
         rd_data[1:0] = mode_reg;
      end
      for (int i = 0; i < 4; i++) begin
         if (hit_preset[i]) begin
            rd_data[7:0] = preset[i];
         end
         if (hit_rdbk[i]) begin
            rd_data[7:0] = corr_out[i].value;
         end
      end
   end

   // One wait-free answer: ack the cycle after the request, then drop
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack      <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   assign wb_ack_o = ack;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `ODS_CTRL_RESET;
         mode_reg <= `ODS_MODE_RESET;
         restart  <= 1'b0;
      end else begin
         restart <= next_restart;
         if (wr_ctrl) begin
            ctrl_reg <= {3'h0, wbyte[4:0]};
         end
         if (wr_mode) begin
            mode_reg <= next_mode;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         preset <= {4{`ODS_PRESET_RESET}};
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_lane && hit_preset[i]) begin
               preset[i] <= wbyte;
            end
         end
      end
   end

   // Wide counter instead of a prescaler chain: one compare, exact period
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer <= '0;
         tick  <= 1'b0;
      end else if (!master_on || restart || !periodic) begin
         timer <= '0;
         tick  <= 1'b0;
      end else if (timer_end) begin
         timer <= '0;
         tick  <= 1'b1;
      end else begin
         timer <= timer + `ODS_TIMER_W'(1);
         tick  <= 1'b0;
      end
   end

   for (genvar c = 0; c < 4; c++) begin : g_chan
      ods_chan u_chan (
         .core_clk  (core_clk),
         .arst_n    (arst_n),
         .master_on (master_on),
         .out_en    (out_sel[c]),
         .op_mode   (mode_reg),
         .restart   (restart),
         .tick      (tick),
         .preset    (preset[c]),
         .meas      (meas_in[c]),
         .meas_req  (meas_req[c]),
         .corr      (corr_out[c])
      );
   end

endmodule : ods_servo_ctrl

// [ods_servo_ctrl_assertions.sv]
// Port checker for the offset servo control
`timescale 1ns/100ps
`include "ods_params.svh"
module ods_servo_ctrl_chk #(
   parameter logic [`ODS_TIMER_W-1:0] UPDATE_CYCLES = 36'd50
) (
   input  wire logic                     core_clk,
   input  wire logic                     arst_n,
   input  wire logic [9:0]               wb_adr_i,
   input  wire logic [31:0]              wb_dat_i,
   input  wire logic [31:0]              wb_dat_o,
   input  wire logic                     wb_we_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_ack_o,
   input  wire ods_pkg::ods_meas_t [3:0] meas_in,
   input  wire logic [3:0]               meas_req,
   input  wire ods_pkg::ods_corr_t [3:0] corr_out
);
   // Shadow of control and mode, written at the taking edge
   logic [4:0] ctl;
   logic [1:0] md;
   wire        tk  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wt  = tk && wb_we_i && wb_sel_i[0];
   wire [3:0]  app = {corr_out[3].apply, corr_out[2].apply,
                      corr_out[1].apply, corr_out[0].apply};
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl <= 5'h10;
         md  <= 2'h0;
      end else begin
         if (wt && wb_adr_i == 10'h10c) ctl <= wb_dat_i[4:0];
         if (wt && wb_adr_i == 10'h114) md <= wb_dat_i[1:0];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_rb_rd;
      tk && !wb_we_i && wb_adr_i == 10'h150;
   endsequence
   // Clearing may lag the master bit by a cycle
   sequence s_off;
      (!ctl[4]) [*3];
   endsequence
   a_ack_next: assert property (tk |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_off_noapply: assert property (!ctl[4] |-> app == 4'h0)
      else $error("correction applied with master off");
   a_off_clear: assert property (
      s_off |-> corr_out[3].value == 8'h00)
      else $error("value kept with master off");
   a_apply_sel: assert property ((app & ~ctl[3:0]) == 4'h0)
      else $error("apply on unselected output");
   a_meas_store: assert property (
      meas_req[3] && meas_in[3].valid |=>
      corr_out[3].value == $past(meas_in[3].value))
      else $error("measurement not stored");
   a_once_quiet: assert property (
      !md[0] && app[2] |-> !meas_req[2])
      else $error("remeasure in a one-shot mode");
   a_preset_quiet: assert property (
      (md == 2'h0) [*3] |-> meas_req == 4'h0)
      else $error("measurement in preset-once mode");
   a_rb_read: assert property (s_rb_rd |=>
      wb_dat_o == {24'h0, $past(corr_out[0].value)})
      else $error("readback differs from live value");
endmodule : ods_servo_ctrl_chk

bind ods_servo_ctrl ods_servo_ctrl_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
   .core_clk, .arst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .meas_in, .meas_req, .corr_out);

// [tb_ods_servo_ctrl.sv]
// Self-checking bench for the offset servo control
`timescale 1ns/100ps
module tb_ods_servo_ctrl;
   localparam int UPD = 50;
   logic                     core_clk = 1'b0;
   logic                     arst_n   = 1'b0;
   logic [9:0]               wb_adr_i = 10'h000;
   logic [31:0]              wb_dat_i = 32'h0;
   logic [31:0]              wb_dat_o;
   logic                     wb_we_i  = 1'b0;
   logic [3:0]               wb_sel_i = 4'h0;
   logic                     wb_cyc_i = 1'b0;
   logic                     wb_stb_i = 1'b0;
   logic                     wb_ack_o;
   ods_pkg::ods_meas_t [3:0] meas_in  = '0;
   logic [3:0]               meas_req;
   ods_pkg::ods_corr_t [3:0] corr_out;
   wire  [3:0]               app = {corr_out[3].apply, corr_out[2].apply,
                                    corr_out[1].apply, corr_out[0].apply};
   logic [7:0]               mv [4]   = '{4{8'h00}};
   logic [7:0]               pv [4]   = '{4{8'h00}};
   logic [7:0]               z [4]    = '{4{8'h00}};
   logic [7:0]               old [4];
   logic [7:0]               expq [$];
   int                       n_fail   = 0;
   int                       compares = 0;
   int                       tn       = 0;
   int                       seed     = 32'h863f;
   // Short interval keeps periodic refreshes inside the run
   ods_servo_ctrl #(.UPDATE_CYCLES(36'd50)) uut (
      .core_clk, .arst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
      .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .meas_in, .meas_req,
      .corr_out);
   always #12.5 core_clk = ~core_clk;
   // Sensor answers one cycle after each request; mv is in register order
   always @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         meas_in[i].valid <= meas_req[i] && !meas_in[i].valid;
         meas_in[i].value <= mv[3-i];
      end
   end
   task automatic check(logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask : check
   // Apply and request levels are settled between edges
   task automatic flags(logic [3:0] a, logic [3:0] m);
      check({4'h0, app}, {4'h0, a});
      check({4'h0, meas_req}, {4'h0, m});
   endtask : flags
   always @(posedge core_clk) begin
      if (wb_ack_o === 1'b1 && !wb_we_i) check(wb_dat_o[7:0], expq.pop_front());
   end
   task automatic bus(logic [9:0] a, logic w, logic [7:0] d);
      int n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_we_i  <= w;
      wb_sel_i <= 4'hf;
      wb_dat_i <= w ? {24'h0, d} : $random(seed);
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         $display("ERROR %0t no ack", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic rd(logic [9:0] a, logic [7:0] e);
      expq.push_back(e);
      bus(a, 1'b0, 8'h00);
   endtask : rd
   task automatic rball(logic [7:0] x [4]);
      for (int j = 0; j < 4; j++) rd(10'h144 + 10'(4 * j), x[j]);
   endtask : rball
   task automatic rnd(output logic [7:0] x [4]);
      for (int j = 0; j < 4; j++) x[j] = 8'($random(seed));
   endtask : rnd
   task automatic done;
      tn++;
      $display("test %0d done", tn);
   endtask : done
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(10'h10c, 8'h10);
      rd(10'h114, 8'h00);
      rball(z);
      rd(10'h3fc, 8'h00);
      done();
      rnd(pv);
      for (int j = 0; j < 4; j++)
         bus(10'h11c + 10'(4 * j), 1'b1, pv[j]);
      for (int j = 0; j < 4; j++) rd(10'h11c + 10'(4 * j), pv[j]);
      bus(10'h144, 1'b1, 8'hff);
      rd(10'h144, 8'h00);
      done();
      bus(10'h10c, 1'b1, 8'h1f);
      repeat (4) @(posedge core_clk);
      rball(pv);
      flags(4'hf, 4'h0);
      bus(10'h10c, 1'b1, 8'h10);
      rball(pv);
      flags(4'h0, 4'h0);
      // Partial reselect also checks the bit to output mapping
      bus(10'h10c, 1'b1, 8'h1a);
      rball(pv);
      flags(4'ha, 4'h0);
      bus(10'h10c, 1'b1, 8'h0f);
      repeat (3) @(posedge core_clk);
      rball(z);
      flags(4'h0, 4'h0);
      done();
      rnd(mv);
      bus(10'h114, 1'b1, 8'h02);
      bus(10'h10c, 1'b1, 8'h1f);
      repeat (8) @(posedge core_clk);
      rball(mv);
      old = mv;
      rnd(mv);
      repeat (2 * UPD) @(posedge core_clk);
      rball(old);
      flags(4'hf, 4'h0);
      done();
      bus(10'h114, 1'b1, 8'h03);
      repeat (8) @(posedge core_clk);
      rball(mv);
      old = mv;
      rnd(mv);
      repeat (UPD / 4) @(posedge core_clk);
      rball(old);
      repeat (UPD) @(posedge core_clk);
      rball(mv);
      done();
      rnd(pv);
      for (int j = 0; j < 4; j++)
         bus(10'h11c + 10'(4 * j), 1'b1, pv[j]);
      bus(10'h114, 1'b1, 8'h01);
      repeat (4) @(posedge core_clk);
      rball(pv);
      // A stale timer would refresh here, before a full interval
      repeat (UPD / 4) @(posedge core_clk);
      rball(pv);
      repeat (UPD + 10) @(posedge core_clk);
      rball(mv);
      done();
      repeat (4) @(posedge core_clk);
      summarize();
   end
endmodule : tb_ods_servo_ctrl
